// ===== bldc_ctl_pkg.sv
// Shared constants and types for the open-loop BLDC PWM control block
package bldc_ctl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 20_000_000;
  // Brake delay time in microseconds, the input inactive time before brake
  localparam int unsigned BRAKE_DELAY_TIME_US = 1000;
  // Longest time: rounded down to whole cycles
  localparam int unsigned BRAKE_CYCLES_DEF = (BRAKE_DELAY_TIME_US * (CLK_FREQ_HZ / 1000)) / 1000;

  // ----------------------------------------------------------------
  // Duty measurement
  // ----------------------------------------------------------------
  localparam int unsigned DUTY_W = 8;
  // Input period counter width: 5 Hz at 20 MHz needs 22 bits
  localparam int unsigned PER_W_DEF = 24;
  localparam logic [8:0] DUTY_FULL = 9'h100;
  localparam logic [8:0] DUTY_ZERO = 9'h000;

  // ----------------------------------------------------------------
  // Recirculation mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] RM_SLOW_HIGH = 3'h0;
  localparam logic [2:0] RM_SLOW_LOW = 3'h1;
  localparam logic [2:0] RM_SLOW_AUTO = 3'h2;
  localparam logic [2:0] RM_FAST = 3'h3;

  // ----------------------------------------------------------------
  // Sequencing counts
  // ----------------------------------------------------------------
  localparam logic [2:0] START_COMM_LAST = 3'h5;   // Six commutations after hold
  localparam logic [2:0] FAULT_LOW_PERIODS = 3'h3;
  localparam logic [2:0] FAULT_CYCLE_LAST = 3'h5;  // Three low plus three high
  localparam logic [1:0] SPD_ELEC_LAST = 2'h2;     // Three commutations per half wave
  localparam logic [7:0] MIX_FAST_SLOTS = 8'h40;   // Fast part of mixed decay, 25 %
  localparam logic [7:0] SLOT_LAST = 8'hff;
  localparam logic [8:0] OFF_TIME_SLOTS = 9'h100;  // One full bridge period

  // ----------------------------------------------------------------
  // Control states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_STOP, ST_START, ST_RUN, ST_BRAKE, ST_FAULT} ctl_state_t;

endpackage

// ===== pin_sync.sv
// Two flip-flop synchroniser for asynchronous input levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

// ===== duty_meter.sv
// Input PWM period and duty measurement with a 9-bit duty counter
`timescale 1ns/1ps
module duty_meter import bldc_ctl_pkg::*; #(
  parameter int unsigned PER_W = PER_W_DEF
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Polarity-corrected input, high while active
  input wire logic active_i,
  // Results
  output logic [DUTY_W:0] duty_o,
  output logic [PER_W-1:0] period_o,
  output logic period_done_o
);

  logic act_d_r;
  logic [PER_W-1:0] per_cnt_r;
  logic [PER_W-DUTY_W-1:0] tick_cnt_r;
  logic [DUTY_W:0] hi_cnt_r;

  // A period ends at the end of each active phase
  wire fall = act_d_r & ~active_i;
  // Last period split into 256 ticks; active ticks give the duty directly
  wire [PER_W-DUTY_W-1:0] tick_len = period_o[PER_W-1:DUTY_W];
  wire tick = (tick_cnt_r + 1'b1 >= tick_len);
  wire per_sat = &per_cnt_r;
  wire hi_inc = tick & active_i & (hi_cnt_r != DUTY_FULL);

  // Measurement counters; the first period after reset is only a rough guess
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      act_d_r <= 1'b0;
      per_cnt_r <= '0;
      tick_cnt_r <= '0;
      hi_cnt_r <= '0;
      duty_o <= '0;
      period_o <= '0;
      period_done_o <= 1'b0;
    end else begin
      act_d_r <= active_i;
      period_done_o <= fall;
      if (fall) begin
        duty_o <= hi_cnt_r;
        period_o <= per_cnt_r;
        per_cnt_r <= PER_W'(1);
        tick_cnt_r <= '0;
        hi_cnt_r <= '0;
      end else begin
        per_cnt_r <= per_sat ? per_cnt_r : per_cnt_r + PER_W'(1);
        tick_cnt_r <= tick ? '0 : tick_cnt_r + (PER_W-DUTY_W)'(1);
        hi_cnt_r <= hi_inc ? hi_cnt_r + (DUTY_W+1)'(1) : hi_cnt_r;
      end
    end
  end

endmodule

// ===== open_loop_bldc_pwm_control.sv
// Open-loop PWM speed control, brake and sync-loss handling for a BLDC driver
//
// Overview of operation
// [R01] Direct mode: inactive input puts bridge in the selected recirculation mode.
// [R02] Decay choices: slow high-side, slow low-side, slow auto, fast without rectifying.
// [R03] Start sequence always uses mixed decay, ignoring the recirculation select.
// [R04] Direct mode: input drives bridge; only the current regulator may cut it.
// [R05] Speed output toggles at commutation or electrical cycle rate, as selected.
// [R06] Controller sets off-time longer than the external PWM period in direct mode.
// [R07] Direct mode: inactive beyond brake time with brake and run set enters brake.
// [R08] Brake turns on all low-side switches and all high-side switches off.
// [R09] Brake holds until input active; then start if run set and brake clear.
// [R10] Direct start ignores duty; inactivity beyond brake time aborts start to brake (here only if brake enable set, else to stop).
// [R11] Sync loss when motor speed drops below a quarter of start speed.
// [R12] Direct sync loss with restart: retry, fault low until six commutations.
// [R13] Direct sync loss without restart: fault stays until zero duty or run clear.
// [R14] Indirect mode: measure input duty, replay at bridge period set by select.
// [R15] Indirect mode: regulator off-time equals bridge period, synced to bridge PWM.
// [R16] Indirect duty is never clamped; zero to full passes through.
// [R17] Indirect sync loss: fault low three periods, high three, repeating.
// [R18] Indirect restart: two fault patterns, then reset sequencer and start again.
// [R19] Indirect without restart: fault pattern continues until zero duty or run clear.
// [R20] Indirect: inactive over twice last period forces bridge off.
// [R21] Indirect: one further inactive period enters brake if brake and run set.
// [R22] Indirect start: duty measured, withheld until six commutations; timeout brakes (here only if brake enable set, else stops).
// [R23] Polarity bit picks active level; duty measured by an 8-bit counter (hi_cnt_r here is 9 bits, 0 to 256).
// [R24] Run clear forces all gates low and stops commutation, over everything.
// [R25] Brake delay time is a parameter of this module.
`timescale 1ns/1ps
module open_loop_bldc_pwm_control import bldc_ctl_pkg::*; #(
  parameter int unsigned BRAKE_CYCLES = BRAKE_CYCLES_DEF,
  parameter int unsigned PER_W = PER_W_DEF
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Pins and comparators from outside the clock domain
  input wire logic pwm_pin_i,
  input wire logic ilim_cmp_i,
  // Configuration and control bits
  input wire logic run_i,
  input wire logic brake_enable_i,
  input wire logic auto_restart_enable_i,
  input wire logic input_polarity_invert_i,
  input wire logic indirect_mode_i,
  input wire logic speed_elec_sel_i,
  input wire logic [2:0] recirc_mode_sel_i,
  input wire logic [4:0] bridge_period_sel_i,
  // Start sequencer and commutation controller
  input wire logic seq_pwm_i,
  input wire logic seq_hold_done_i,
  input wire logic comm_tick_i,
  input wire logic comm_auto_high_i,
  input wire logic [2:0] comm_hi_phase_i,
  input wire logic [2:0] comm_lo_phase_i,
  input wire logic [15:0] motor_period_i,
  input wire logic [15:0] start_period_i,
  // Bridge gate drive
  output logic [2:0] gate_hs_o,
  output logic [2:0] gate_ls_o,
  // Open-drain fault pin and speed pin
  output logic error_flag_out_l_o,
  output logic error_flag_oe_l_o,
  output logic speed_pulse_out_o,
  // Sequencer requests and status
  output logic start_req_o,
  output logic seq_reset_o,
  output logic brake_active_o,
  output logic [DUTY_W:0] duty_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Gate pattern {high, low} for the PWM-off part of the cycle
  function automatic logic [5:0] decay_gates(input logic [2:0] mode, input logic auto_high,
                                             input logic [2:0] hi, input logic [2:0] lo);
    logic [2:0] both;
    both = hi | lo;
    unique case (mode)
      RM_SLOW_HIGH: decay_gates = {both, 3'h0}; // R02
      RM_SLOW_LOW: decay_gates = {3'h0, both}; // R02
      RM_SLOW_AUTO: decay_gates = auto_high ? {both, 3'h0} : {3'h0, both}; // R02
      default: decay_gates = 6'h00; // R02
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Input conditioning and measurement
  // ----------------------------------------------------------------

  logic [1:0] in_sync;
  logic [PER_W-1:0] per_meas;
  logic per_done;

  pin_sync #(
    .W(2)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i({ilim_cmp_i, pwm_pin_i}),
    .sync_o(in_sync)
  );

  // Active level after polarity correction
  wire pwm_act = in_sync[0] ^ input_polarity_invert_i; // R23
  wire ilim = in_sync[1];

  duty_meter #(
    .PER_W(PER_W)
  ) u_duty_meter (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .active_i(pwm_act), // R23
    .duty_o(duty_o), // R14
    .period_o(per_meas),
    .period_done_o(per_done)
  );

  // ----------------------------------------------------------------
  // Inactivity timing
  // ----------------------------------------------------------------

  logic [PER_W+1:0] inact_r;
  wire inact_sat = &inact_r;
  wire [PER_W+1:0] per_x2 = {1'b0, per_meas, 1'b0};
  wire [PER_W+1:0] per_x3 = per_x2 + {2'b00, per_meas};

  // Indirect timeouts scale with the last measured input period
  wire ind_forced_off = (inact_r > per_x2); // R20
  wire ind_brake_due = (inact_r > per_x3); // R21
  wire dir_brake_due = (inact_r > (PER_W+2)'(BRAKE_CYCLES)); // R25
  wire brake_due = indirect_mode_i ? ind_brake_due : dir_brake_due;
  // Zero duty: held inactive in direct mode, measured zero or forced off in indirect mode
  wire zero_duty = indirect_mode_i ? ((duty_o == DUTY_ZERO) | ind_forced_off) : dir_brake_due;
  // Speed below a quarter of start speed means period over four times start
  wire sync_lost = ({2'b00, motor_period_i} > {start_period_i, 2'b00}); // R11

  // Saturating count of inactive cycles, cleared by any active cycle
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      inact_r <= '0;
    end else begin
      inact_r <= pwm_act ? '0 : (inact_sat ? inact_r : inact_r + (PER_W+2)'(1));
    end
  end

  // ----------------------------------------------------------------
  // Bridge PWM timebase and current regulator
  // ----------------------------------------------------------------

  logic [4:0] pre_r;
  logic [7:0] slot_r;
  logic lim_latch_r;
  logic [8:0] off_left_r;
  logic [7:0] decay_r;

  // Bridge period is 256 slots of (select + 1) clocks each
  wire slot_tick = (pre_r == bridge_period_sel_i); // R14
  wire slot_wrap = slot_tick & (slot_r == SLOT_LAST);
  // Nine-bit compare lets a full-scale duty stay on for the whole period
  wire bridge_on = ({1'b0, slot_r} < duty_o); // R16
  wire off_busy = (off_left_r != 9'h000);
  wire reg_off = indirect_mode_i ? lim_latch_r : off_busy;
  wire mix_fast = (decay_r < MIX_FAST_SLOTS);

  // Prescaler and slot counter run freely so the off-time stays in step
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_r <= '0;
      slot_r <= '0;
    end else begin
      pre_r <= slot_tick ? 5'h00 : pre_r + 5'h01;
      slot_r <= slot_tick ? slot_r + 8'h01 : slot_r;
    end
  end

  // Indirect regulator: a trip holds PWM-off until the bridge period ends.
  // Set wins over the end-of-period clear so no trip is lost.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lim_latch_r <= 1'b0;
    end else begin
      lim_latch_r <= ilim | (lim_latch_r & ~slot_wrap); // R15
    end
  end

  // Direct regulator: fixed off-time of one bridge period from the trip.
  // Only ever forces off, since it is longer than the external period.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      off_left_r <= '0;
    end else if (ilim & ~off_busy) begin
      off_left_r <= OFF_TIME_SLOTS; // R04
    end else if (slot_tick & off_busy) begin
      off_left_r <= off_left_r - 9'h001; // R06
    end
  end

  // ----------------------------------------------------------------
  // Control state machine
  // ----------------------------------------------------------------

  ctl_state_t st_r;
  ctl_state_t st_nxt;
  logic [2:0] comm_cnt_r;
  logic [2:0] comm_cnt_nxt;
  logic [2:0] fpat_r;
  logic [2:0] fpat_nxt;
  logic frep_r;
  logic frep_nxt;
  logic hold_r;
  logic hold_nxt;
  logic start_nxt;
  logic seqrst_nxt;

  wire restart_ok = run_i & auto_restart_enable_i & ~zero_duty;
  wire comm_step = comm_tick_i & seq_hold_done_i;

  // Next state, start and restart requests, fault pattern counting
  always_comb begin
    st_nxt = st_r;
    comm_cnt_nxt = comm_cnt_r;
    fpat_nxt = fpat_r;
    frep_nxt = frep_r;
    hold_nxt = hold_r;
    start_nxt = 1'b0;
    seqrst_nxt = 1'b0;
    unique case (st_r)
      ST_STOP: begin
        if (run_i & brake_enable_i & brake_due) begin
          st_nxt = ST_BRAKE; // R07
        end else if (run_i & pwm_act) begin
          st_nxt = ST_START;
          start_nxt = 1'b1;
          comm_cnt_nxt = 3'h0;
        end
      end
      ST_START: begin
        if (brake_due) begin
          st_nxt = brake_enable_i ? ST_BRAKE : ST_STOP; // R10 R22
          hold_nxt = 1'b0;
        end else if (comm_step) begin
          if (comm_cnt_r == START_COMM_LAST) begin
            st_nxt = ST_RUN; // R22
            hold_nxt = 1'b0; // R12
          end else begin
            comm_cnt_nxt = comm_cnt_r + 3'h1;
          end
        end
      end
      ST_RUN: begin
        if (sync_lost) begin
          st_nxt = ST_FAULT; // R11
          fpat_nxt = 3'h0;
          frep_nxt = 1'b0;
        end else if (brake_enable_i & brake_due) begin
          st_nxt = ST_BRAKE; // R07 R21
        end
      end
      ST_BRAKE: begin
        if (pwm_act) begin
          st_nxt = brake_enable_i ? ST_STOP : ST_START; // R09
          start_nxt = ~brake_enable_i; // R09
          comm_cnt_nxt = 3'h0;
        end
      end
      ST_FAULT: begin
        if (zero_duty) begin
          st_nxt = ST_STOP; // R13 R19
        end else if (!indirect_mode_i) begin
          if (restart_ok) begin
            st_nxt = ST_START; // R12
            start_nxt = 1'b1;
            seqrst_nxt = 1'b1;
            hold_nxt = 1'b1; // R12
            comm_cnt_nxt = 3'h0;
          end
        end else if (per_done) begin
          fpat_nxt = (fpat_r == FAULT_CYCLE_LAST) ? 3'h0 : fpat_r + 3'h1; // R17
          if (fpat_r == FAULT_CYCLE_LAST) begin
            frep_nxt = ~frep_r;
            if (frep_r & restart_ok) begin
              st_nxt = ST_START; // R18
              start_nxt = 1'b1;
              seqrst_nxt = 1'b1;
              comm_cnt_nxt = 3'h0;
            end
          end
        end
      end
      default: st_nxt = ST_STOP;
    endcase
    // Run clear overrides every other control input
    if (!run_i) begin
      st_nxt = ST_STOP; // R24
      hold_nxt = 1'b0;
      start_nxt = 1'b0;
      seqrst_nxt = 1'b0;
    end
  end

  // State register and sequencing counters
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= ST_STOP;
      comm_cnt_r <= '0;
      fpat_r <= '0;
      frep_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      comm_cnt_r <= comm_cnt_nxt;
      fpat_r <= fpat_nxt;
      frep_r <= frep_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Bridge drive selection
  // ----------------------------------------------------------------

  logic pwm_on;
  logic [5:0] gate_nxt;

  // Direct mode passes the pin; indirect replays measured duty.
  // During start the sequencer owns the duty, input duty is not used.
  wire dir_on = pwm_act & ~reg_off; // R04
  wire ind_on = bridge_on & ~reg_off & ~ind_forced_off; // R14 R20
  wire [2:0] mode_eff = (st_r == ST_START) ? (mix_fast ? RM_FAST : RM_SLOW_LOW)
                                           : recirc_mode_sel_i; // R03
  wire [5:0] off_gates = decay_gates(mode_eff, comm_auto_high_i, comm_hi_phase_i,
                                     comm_lo_phase_i); // R01

  always_comb begin
    unique case (st_r)
      ST_START: pwm_on = seq_pwm_i & ~reg_off; // R10 R22
      ST_RUN: pwm_on = indirect_mode_i ? ind_on : dir_on;
      default: pwm_on = 1'b0;
    endcase
  end

  // Gate pattern for the next cycle
  always_comb begin
    gate_nxt = 6'h00;
    if (!run_i) begin
      gate_nxt = 6'h00; // R24
    end else if (st_r == ST_BRAKE) begin
      gate_nxt = {3'h0, 3'h7}; // R08
    end else if ((st_r == ST_START) || (st_r == ST_RUN)) begin
      gate_nxt = pwm_on ? {comm_hi_phase_i, comm_lo_phase_i} : off_gates; // R01
    end
  end

  // Slots spent in PWM-off, used to time the fast part of mixed decay
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      decay_r <= '0;
    end else if (pwm_on) begin
      decay_r <= '0;
    end else if (slot_tick & (decay_r != SLOT_LAST)) begin
      decay_r <= decay_r + 8'h01; // R03
    end
  end

  // ----------------------------------------------------------------
  // Speed and fault outputs
  // ----------------------------------------------------------------

  logic [1:0] spd_cnt_r;
  wire spd_last = ~speed_elec_sel_i | (spd_cnt_r == SPD_ELEC_LAST);
  // Fault is low for the whole direct fault or restart, patterned in indirect
  wire fault_low = hold_r |
                   ((st_r == ST_FAULT) & (~indirect_mode_i | (fpat_r < FAULT_LOW_PERIODS))); // R17

  // Speed pin: half wave is one commutation, or three for a full electrical cycle
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spd_cnt_r <= '0;
      speed_pulse_out_o <= 1'b0;
    end else if (comm_tick_i & run_i) begin
      spd_cnt_r <= spd_last ? 2'h0 : spd_cnt_r + 2'h1;
      speed_pulse_out_o <= spd_last ? ~speed_pulse_out_o : speed_pulse_out_o; // R05
    end
  end

  // Registered outputs; the fault pin only ever pulls low
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_hs_o <= '0;
      gate_ls_o <= '0;
      error_flag_out_l_o <= 1'b0;
      error_flag_oe_l_o <= 1'b1;
      start_req_o <= 1'b0;
      seq_reset_o <= 1'b0;
      brake_active_o <= 1'b0;
    end else begin
      gate_hs_o <= gate_nxt[5:3];
      gate_ls_o <= gate_nxt[2:0];
      error_flag_out_l_o <= 1'b0;
      error_flag_oe_l_o <= ~fault_low; // R12 R13
      start_req_o <= start_nxt;
      seq_reset_o <= seqrst_nxt; // R18
      brake_active_o <= (st_nxt == ST_BRAKE);
    end
  end

endmodule

// ===== bldc_ctl_assertions.sv
// Port checker for the open-loop BLDC PWM control block
`timescale 1ns/1ps
module bldc_ctl_assertions import bldc_ctl_pkg::*; #(
  parameter int unsigned BRAKE_CYCLES = BRAKE_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Watched inputs
  input wire logic pwm_pin_i,
  input wire logic run_i,
  input wire logic brake_enable_i,
  input wire logic input_polarity_invert_i,
  input wire logic indirect_mode_i,
  // Watched outputs
  input wire logic [2:0] gate_hs_o,
  input wire logic [2:0] gate_ls_o,
  input wire logic error_flag_out_l_o,
  input wire logic start_req_o,
  input wire logic seq_reset_o,
  input wire logic brake_active_o,
  input wire logic [DUTY_W:0] duty_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------------------------------
  // Idle helper: raw pin time, so it runs ahead of the synchroniser
  // ----------------------------------------------------------------
  logic [31:0] idle_cnt_r;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_cnt_r <= 32'h0000_0000;
    end else if (pwm_pin_i ^ input_polarity_invert_i) begin
      idle_cnt_r <= 32'h0000_0000;
    end else begin
      idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_run_off_gates: assert property (!run_i [*3] |-> gate_hs_o == 3'h0 && gate_ls_o == 3'h0)
    else $error("gates driven while run is clear");
  a_brake_low_side: assert property ((run_i && brake_active_o) [*2] |-> gate_ls_o == 3'h7 && gate_hs_o == 3'h0)
    else $error("brake without all low sides on");
  a_brake_enabled: assert property ($rose(brake_active_o) |-> $past(brake_enable_i) && $past(run_i))
    else $error("brake entered without enable and run");
  a_brake_delay: assert property ($rose(brake_active_o) && !indirect_mode_i |-> idle_cnt_r > BRAKE_CYCLES)
    else $error("brake entered before the delay ran out");
  a_start_pulse: assert property (start_req_o |=> !start_req_o)
    else $error("start request longer than one cycle");
  a_start_needs_run: assert property (start_req_o |-> $past(run_i))
    else $error("start request while run clear");
  a_seq_pair: assert property (seq_reset_o |-> start_req_o)
    else $error("sequencer reset without start request");
  a_fault_data_low: assert property (error_flag_out_l_o == 1'b0)
    else $error("fault pin data not low");
  a_duty_full: assert property (duty_o <= DUTY_FULL)
    else $error("duty above full scale");
endmodule

bind open_loop_bldc_pwm_control bldc_ctl_assertions #(.BRAKE_CYCLES(BRAKE_CYCLES)) u_chk (
  .clk_sys_i, .reset_n_i, .pwm_pin_i, .run_i, .brake_enable_i, .input_polarity_invert_i,
  .indirect_mode_i, .gate_hs_o, .gate_ls_o, .error_flag_out_l_o, .start_req_o, .seq_reset_o,
  .brake_active_o, .duty_o);

// ===== pwm_source_model.sv
// Behavioural PWM source standing in for the controller that drives the pin
`timescale 1ns/1ps
module pwm_source_model (
  // Clock
  input wire logic clk_sys_i,
  // Waveform settings
  input wire logic en_i,
  input wire logic invert_i,
  input wire logic [15:0] period_i,
  input wire logic [15:0] on_i,
  // Pin
  output logic pwm_pin_o
);
  logic [15:0] cnt_r;
  initial begin
    cnt_r = 16'h0000;
    pwm_pin_o = 1'b0;
  end
  // Period kept below the bridge off-time by the direct-mode bench settings
  always @(posedge clk_sys_i) begin
    cnt_r <= (cnt_r >= period_i - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
    pwm_pin_o <= (en_i && cnt_r < on_i) ^ invert_i;
  end
endmodule

// ===== open_loop_bldc_pwm_control_tb.sv
// Self-checking bench for the open-loop BLDC PWM control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WAIT(c, n) begin for (int k = 0; k < (n) && !(c); k++) step(1); \
  if (!(c)) begin err_count++; $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1); \
  summarize(); end end
module open_loop_bldc_pwm_control_tb import bldc_ctl_pkg::*;;
  logic clk_sys_i, reset_n_i, pwm_pin_i, ilim_cmp_i, run_i, brake_enable_i;
  logic auto_restart_enable_i, input_polarity_invert_i, indirect_mode_i, speed_elec_sel_i;
  logic seq_pwm_i, seq_hold_done_i, comm_tick_i, comm_auto_high_i, m_en, s;
  logic [2:0] recirc_mode_sel_i, comm_hi_phase_i, comm_lo_phase_i, gate_hs_o, gate_ls_o;
  logic [4:0] bridge_period_sel_i;
  logic [15:0] motor_period_i, start_period_i, m_per, m_on;
  logic error_flag_out_l_o, error_flag_oe_l_o, speed_pulse_out_o, start_req_o, seq_reset_o;
  logic brake_active_o;
  logic [DUTY_W:0] duty_o;
  logic [11:0] rows [8];
  int err_count = 0;
  int n_compared = 0;
  // Short brake delay keeps the run brief
  open_loop_bldc_pwm_control #(.BRAKE_CYCLES(400)) dut (.clk_sys_i, .reset_n_i, .pwm_pin_i,
    .ilim_cmp_i, .run_i, .brake_enable_i, .auto_restart_enable_i, .input_polarity_invert_i,
    .indirect_mode_i, .speed_elec_sel_i, .recirc_mode_sel_i, .bridge_period_sel_i, .seq_pwm_i,
    .seq_hold_done_i, .comm_tick_i, .comm_auto_high_i, .comm_hi_phase_i, .comm_lo_phase_i,
    .motor_period_i, .start_period_i, .gate_hs_o, .gate_ls_o, .error_flag_out_l_o,
    .error_flag_oe_l_o, .speed_pulse_out_o, .start_req_o, .seq_reset_o, .brake_active_o, .duty_o);
  pwm_source_model u_src (.clk_sys_i, .en_i(m_en), .invert_i(input_polarity_invert_i),
    .period_i(m_per), .on_i(m_on), .pwm_pin_o(pwm_pin_i));
  // 20 MHz clock
  initial clk_sys_i = 1'b0;
  always #25 clk_sys_i = ~clk_sys_i;
  // ----------------------------------------------------------------
  // Helpers: inputs always move 2 ns after the rising edge
  // ----------------------------------------------------------------
  task step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask
  task ticks(input int n);
    repeat (n) begin
      comm_tick_i = 1'b1;
      step(1);
      comm_tick_i = 1'b0;
      step(1);
    end
  endtask
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    // Row: mode, auto high, input active, limit trip, expected high and low gates
    rows = '{12'h08a, 12'h018, 12'h203, 12'h518, 12'h403, 12'h600, 12'he00, 12'h2c3};
    {run_i, brake_enable_i, auto_restart_enable_i, input_polarity_invert_i} = 4'h0;
    {indirect_mode_i, speed_elec_sel_i, seq_pwm_i, seq_hold_done_i} = 4'h0;
    {comm_tick_i, comm_auto_high_i, ilim_cmp_i, m_en} = 4'h0;
    recirc_mode_sel_i = 3'h0;
    bridge_period_sel_i = 5'h00;
    comm_hi_phase_i = 3'h1;
    comm_lo_phase_i = 3'h2;
    motor_period_i = 16'h0040;
    start_period_i = 16'h0040;
    m_per = 16'h0028;
    m_on = 16'h0014;
    reset_n_i = 1'b0;
    step(6);
    reset_n_i = 1'b1;
    step(2);
    `CHK({gate_hs_o, gate_ls_o, error_flag_oe_l_o, brake_active_o, start_req_o}, 9'h004)
    run_i = 1'b1;
    m_en = 1'b1;
    `WAIT(start_req_o, 20)
    `CHK(seq_reset_o, 1'b0)
    seq_hold_done_i = 1'b1;
    ticks(6);
    step(4);
    // Decay and drive table in running state
    for (int i = 0; i < 8; i++) begin
      {recirc_mode_sel_i, comm_auto_high_i} = rows[i][11:8];
      m_on = rows[i][7] ? m_per : 16'h0000;
      ilim_cmp_i = rows[i][6];
      step(8);
      `CHK({gate_hs_o, gate_ls_o}, rows[i][5:0])
    end
    ilim_cmp_i = 1'b0;
    step(300);
    s = speed_pulse_out_o;
    ticks(1);
    step(2);
    `CHK(speed_pulse_out_o, ~s)
    // Sync loss right at and just past four times start period
    motor_period_i = 16'h0100;
    step(6);
    `CHK(error_flag_oe_l_o, 1'b1)
    motor_period_i = 16'h0101;
    step(6);
    `CHK(error_flag_oe_l_o, 1'b0)
    step(30);
    `CHK(error_flag_oe_l_o, 1'b0)
    run_i = 1'b0;
    step(4);
    `CHK({gate_hs_o, gate_ls_o, error_flag_oe_l_o}, 7'h01)
    // Brake entry, exit and start abort with the input active low
    motor_period_i = 16'h0040;
    input_polarity_invert_i = 1'b1;
    m_on = 16'h0014;
    brake_enable_i = 1'b1;
    run_i = 1'b1;
    `WAIT(start_req_o, 20)
    ticks(6);
    step(4);
    m_en = 1'b0;
    `WAIT(brake_active_o, 600)
    step(1);
    `CHK({gate_hs_o, gate_ls_o}, 6'h07)
    brake_enable_i = 1'b0;
    m_en = 1'b1;
    `WAIT(start_req_o, 20)
    `CHK(brake_active_o, 1'b0)
    brake_enable_i = 1'b1;
    m_en = 1'b0;
    `WAIT(brake_active_o, 600)
    step(1);
    `CHK(gate_ls_o, 3'h7)
    // Indirect duty measurement of a quarter-on input
    run_i = 1'b0;
    input_polarity_invert_i = 1'b0;
    indirect_mode_i = 1'b1;
    m_per = 16'h0200;
    m_on = 16'h0080;
    m_en = 1'b1;
    step(1700);
    `CHK(duty_o, 9'h040)
    summarize();
  end
endmodule
